// >>> sim/dac_control_and_monitor_regs_bench.sv
// Testbench for the output configuration and monitor block
`timescale 1ns/1ps
module dac_control_and_monitor_regs_bench;
    import dac_cfg_pkg::*;

    // Row of a config write and the register value it should leave
    typedef struct packed {
        logic [13:0] data;
        logic [13:0] expect_cfg;
    } row_type;

    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic load_strobe_n = 1'b1;
    logic clk_en = 1'b1;
    logic over_temp = 1'b0;
    logic sync_n, sclk, din, sdo;
    logic amps_pd, amps_hiz, amps_gnd, ref_en, ref_2v5, boost, therm, mon_mode;
    logic mon_route, mon_hiz;
    logic [5:0] mon_channel;
    logic [CHANNELS-1:0] toggle_b;
    logic [7:0] status;
    logic [23:0] rd_word;
    logic [39:0] exp_tog;
    logic [39:0] mask;
    int fails = 0;
    int samples_checked = 0;
    row_type rows [7] = '{'{14'h3FFF, 14'h3F7C}, '{14'h0000, 14'h0000},
        '{14'h1400, 14'h1400}, '{14'h1000, 14'h1000}, '{14'h0800, 14'h0800},
        '{14'h0400, 14'h0400}, '{14'h0083, 14'h0000}};
    logic [4:0] tog_pat [3] = '{5'h01, 5'h10, 5'h0A};
    logic [5:0] mon_ch [8] = '{6'h00, 6'h01, 6'h26, 6'h27, 6'h28, 6'h3E, 6'h3F, 6'h05};

    // System clock, 100 MHz
    always #5 clk_sys = ~clk_sys;

    // Status bits gathered for one compare
    assign status = {amps_pd, amps_hiz, amps_gnd, ref_en, ref_2v5, boost, therm, mon_mode};

    serial_host_model host (
        .sync_n_out(sync_n),
        .sclk_out(sclk),
        .din_out(din),
        .sdo_in(sdo)
    );

    dac_output_config dut (
        .clk_sys_in(clk_sys),
        .rst_n_in(rst_n),
        .clk_en_in(clk_en),
        .sync_n_in(sync_n),
        .sclk_in(sclk),
        .din_in(din),
        .sdo_out(sdo),
        .load_strobe_n_in(load_strobe_n),
        .over_temp_in(over_temp),
        .amps_powered_down_out(amps_pd),
        .amps_hiz_out(amps_hiz),
        .amps_load_to_ground_out(amps_gnd),
        .internal_ref_en_out(ref_en),
        .ref_level_2v5_out(ref_2v5),
        .current_boost_out(boost),
        .thermal_shutdown_out(therm),
        .monitor_mode_out(mon_mode),
        .monitor_route_en_out(mon_route),
        .monitor_channel_out(mon_channel),
        .monitor_hiz_out(mon_hiz),
        .toggle_select_b_out(toggle_b)
    );

    // Expected status from config value and power state
    function automatic logic [7:0] status_of(input logic [13:0] cfg, input logic soft_pd,
            input logic trip);
        logic pd;
        logic ref_on;
        pd = soft_pd | trip;
        ref_on = cfg[10] & ~soft_pd;
        return {pd, pd & cfg[13], pd & ~cfg[13], ref_on, ref_on & cfg[12], cfg[11], trip,
            cfg[9]};
    endfunction : status_of

    // Compare and count
    task automatic check(input logic [39:0] seen, input logic [39:0] expected);
        samples_checked++;
        if (seen !== expected) begin
            fails++;
            $display("ERROR %0t mismatch seen %h expected %h", $time, seen, expected);
        end
    endtask : check

    // One special command frame, then let its effects land
    task automatic cmd(input logic rw, input logic [5:0] addr, input logic [13:0] data);
        host.send_frame({1'b0, rw, addr, 2'b00, data}, rd_word);
        repeat (4) @(negedge clk_sys);
    endtask : cmd

    // Read back config, shifted out by a following no-op frame
    task automatic read_cfg(input logic [13:0] expected);
        cmd(1'b1, ADDR_CONFIG, 14'h0000);
        cmd(1'b0, 6'h00, 14'h0000);
        check(40'(rd_word), 40'({10'h000, expected}));
    endtask : read_cfg

    // Verdict and end of run
    task automatic complete_run();
        if (fails == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    // Watchdog against a hung run
    initial begin
        #500000;
        fails++;
        complete_run();
    end

    initial begin
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        check(40'(status), 40'(status_of(14'h2000, 1'b0, 1'b0)));
        check(40'({mon_route, mon_hiz, mon_channel, sdo}), 40'h07E);
        check(toggle_b, 40'h0);
        read_cfg(14'h2000);
        foreach (rows[i]) begin
            cmd(1'b0, ADDR_CONFIG, rows[i].data);
            check(40'(status), 40'(status_of(rows[i].expect_cfg, 1'b0, 1'b0)));
            read_cfg(rows[i].expect_cfg);
        end
        over_temp = 1'b1;
        repeat (8) @(negedge clk_sys);
        check(40'(status), 40'(status_of(14'h0000, 1'b0, 1'b0)));
        over_temp = 1'b0;
        cmd(1'b0, ADDR_CONFIG, 14'h2100);
        over_temp = 1'b1;
        repeat (8) @(negedge clk_sys);
        check(40'(status), 40'(status_of(14'h2100, 1'b0, 1'b1)));
        cmd(1'b0, ADDR_SOFT_PU, 14'h0000);
        check(40'(status), 40'(status_of(14'h2100, 1'b0, 1'b1)));
        over_temp = 1'b0;
        repeat (8) @(negedge clk_sys);
        cmd(1'b0, ADDR_SOFT_PU, 14'h0000);
        check(40'(status), 40'(status_of(14'h2100, 1'b0, 1'b0)));
        cmd(1'b0, ADDR_CONFIG, 14'h0C00);
        cmd(1'b0, ADDR_SOFT_PD, 14'h0000);
        check(40'(status), 40'(status_of(14'h0C00, 1'b1, 1'b0)));
        cmd(1'b0, ADDR_CONFIG, 14'h2000);
        check(40'(status), 40'(status_of(14'h0C00, 1'b1, 1'b0)));
        cmd(1'b0, ADDR_SOFT_PU, 14'h0000);
        check(40'(status), 40'(status_of(14'h0C00, 1'b0, 1'b0)));
        exp_tog = '0;
        foreach (tog_pat[i]) begin
            cmd(1'b0, ADDR_CONFIG, {7'h00, tog_pat[i], 2'b11});
            for (int g = 0; g < 5; g++) begin
                mask[g*8 +: 8] = {8{tog_pat[i][g]}};
            end
            for (int k = 0; k < 2; k++) begin
                load_strobe_n = 1'b0;
                repeat (4) @(negedge clk_sys);
                load_strobe_n = 1'b1;
                repeat (6) @(negedge clk_sys);
                exp_tog = exp_tog ^ mask;
                check(toggle_b, exp_tog);
            end
        end
        cmd(1'b0, ADDR_CONFIG, 14'h0200);
        foreach (mon_ch[i]) begin
            cmd(1'b0, ADDR_MONITOR, {mon_ch[i], 8'hA5});
            check(40'({mon_route, mon_hiz, mon_channel}),
                40'({mon_ch[i] <= 6'h27, mon_ch[i] > 6'h27, mon_ch[i]}));
        end
        // monitor off returns pin to normal output
        cmd(1'b0, ADDR_CONFIG, 14'h0000);
        check(40'({mon_mode, mon_route, mon_hiz}), 40'h0);
        // Soft reset command restores config and monitor code
        cmd(1'b0, ADDR_SOFT_RESET, 14'h0000);
        check(40'(status), 40'(status_of(14'h2000, 1'b0, 1'b0)));
        check(40'(mon_channel), 40'h3F);
        // Frame sent while clock enable is low is lost
        clk_en = 1'b0;
        cmd(1'b0, ADDR_CONFIG, 14'h0800);
        clk_en = 1'b1;
        repeat (4) @(negedge clk_sys);
        check(40'(status), 40'(status_of(14'h2000, 1'b0, 1'b0)));
        // Reset in mid-run brings back the power-up state
        cmd(1'b0, ADDR_CONFIG, 14'h0F00);
        check(40'(status), 40'(status_of(14'h0F00, 1'b0, 1'b0)));
        rst_n = 1'b0;
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        check(40'(status), 40'(status_of(14'h2000, 1'b0, 1'b0)));
        check(40'(mon_channel), 40'h3F);
        read_cfg(14'h2000);
        complete_run();
    end
endmodule : dac_control_and_monitor_regs_bench

// >>> sim/serial_host_model.sv
// Host model that sends command frames on the serial command port
`timescale 1ns/1ps
module serial_host_model (
    // Serial pins toward the block
    output logic sync_n_out,
    output logic sclk_out,
    output logic din_out,
    // Readback pin from the block
    input wire logic sdo_in
);
    // Half period of a 125 ns serial clock
    localparam real HALF_NS = 62.5;

    // Idle levels, serial clock parked high between frames
    initial begin
        sync_n_out = 1'b1;
        sclk_out = 1'b1;
        din_out = 1'b0;
    end

    task automatic send_frame(input logic [23:0] word, output logic [23:0] rd_data);
        int i;
        sync_n_out = 1'b0;
        for (i = 23; i >= 0; i--) begin
            din_out = word[i];
            #(HALF_NS);
            sclk_out = 1'b0;
            rd_data[i] = sdo_in; // Readback valid on falling edge
            #(HALF_NS);
            sclk_out = 1'b1;
        end
        sync_n_out = 1'b1;
        din_out = ~word[0]; // Released data line must not look held
        #(4.0 * HALF_NS);
    endtask : send_frame
endmodule : serial_host_model

// >>> verilog/dac_cfg_pkg.sv
// Constants and types for the output configuration and monitor block
// What this block does
// - Special command 001100 writes config with read/write low unless soft powered down, reads back when high.
// - Power-down state bit high floats amplifiers, low loads them to ground.
// - Reference level bit picks 2.5 V or 1.25 V, only with internal reference.
// - Current boost bit turns amplifier boost on; off after reset.
// - Reference source bit enables internal reference; external after reset.
// - Monitor enable routes the later selected channel onto the last channel pin.
// - Monitor enable resets low; the shared pin then stays an ordinary output.
// - Thermal enable powers down all amplifiers when die is over temperature.
// - Thermal enable bit resets low, meaning disabled.
// - After thermal trip amplifiers stay off until soft power-up with die cool.
// - Config bits 7, 1 and 0 are ignored on write.
// - Each of five toggle bits enables toggle mode for eight channels.
// - Toggle bits map upward: lowest bit channels 0-7, highest 32-39.
// - In enabled toggle groups each load strobe swaps output between A and B.
// - Special command 001010 takes monitored channel from top six data bits, except while soft powered down.
// - Monitor addresses 0 to 39 route that channel to the monitor output.
// - Monitor address 63 three-states the monitor output.
// - Special commands have both register select bits low, decoded by address.
// - Special command 001001 powers amplifiers and internal reference back up.
// - Commands are 24-bit frames sent most significant bit first.
package dac_cfg_pkg;
    // Frame and command codes
    localparam int FRAME_BITS = 24;
    localparam logic [5:0] ADDR_SOFT_PD = 6'h08;
    localparam logic [5:0] ADDR_SOFT_PU = 6'h09;
    localparam logic [5:0] ADDR_MONITOR = 6'h0A;
    localparam logic [5:0] ADDR_CONFIG = 6'h0C;
    localparam logic [5:0] ADDR_SOFT_RESET = 6'h0F;
    // Config reset value and writable bits
    localparam logic [13:0] CONFIG_RESET = 14'h2000;
    localparam logic [13:0] CONFIG_WRITE_MASK = 14'h3F7C;
    // Channel and monitor figures
    localparam int TOGGLE_GROUPS = 5;
    localparam int GROUP_SIZE = 8;
    localparam int CHANNELS = 40;
    localparam logic [5:0] MON_LAST_CHANNEL = 6'h27;
    localparam logic [5:0] MON_THREE_STATE = 6'h3F;
    localparam logic [9:0] READBACK_PAD = 10'h000;

    // One serial command frame, first bit on top
    typedef struct packed {
        logic ab_select;
        logic rw;
        logic [5:0] channel_address_field;
        logic register_select_high;
        logic register_select_low;
        logic [13:0] command_data_field;
    } frame_type;

    // Output configuration register layout
    typedef struct packed {
        logic amp_powerdown_state_bit;
        logic reference_level_bit;
        logic current_boost_bit;
        logic reference_source_bit;
        logic monitor_enable_bit;
        logic thermal_shutdown_enable_bit;
        logic unused_bit_7;
        logic [4:0] toggle_group_enables;
        logic unused_bit_1;
        logic unused_bit_0;
    } config_type;

    // Receiver states, Gray along the frame
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_SHIFT = 2'b01,
        RX_FULL = 2'b11
    } rx_state_type;
endpackage : dac_cfg_pkg

// >>> verilog/dac_frame_receiver.sv
// Serial command frame receiver sampled by the system clock
`timescale 1ns/1ps
module dac_frame_receiver
    import dac_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    // Serial pins
    input wire logic sync_n_in,
    input wire logic sclk_in,
    input wire logic din_in,
    // Frame out
    output frame_type frame_out,
    output logic frame_valid_out,
    output logic sclk_rise_out
);
    typedef struct packed {
        logic sclk_meta;
        logic sclk_sync;
        logic sclk_prev;
        logic sync_meta;
        logic sync_sync;
        logic sync_prev;
        logic din_meta;
        logic din_sync;
        rx_state_type state;
        logic [4:0] count;
        logic [23:0] shift;
        logic frame_valid;
        frame_type frame;
    } rx_reg_type;

    rx_reg_type s;
    rx_reg_type next_s;
    logic sclk_fall;
    logic sync_fall;
    logic sync_rise;

    // Edge detection on synchronised pins
    assign sclk_fall = s.sclk_prev & ~s.sclk_sync;
    assign sync_fall = s.sync_prev & ~s.sync_sync;
    assign sync_rise = ~s.sync_prev & s.sync_sync;
    assign sclk_rise_out = (s.state == RX_SHIFT) & ~s.sclk_prev & s.sclk_sync;
    assign frame_out = s.frame;
    assign frame_valid_out = s.frame_valid;

    // Next state of the receiver
    always_comb begin
        next_s = s;
        next_s.sclk_meta = sclk_in;
        next_s.sclk_sync = s.sclk_meta;
        next_s.sclk_prev = s.sclk_sync;
        next_s.sync_meta = sync_n_in;
        next_s.sync_sync = s.sync_meta;
        next_s.sync_prev = s.sync_sync;
        next_s.din_meta = din_in;
        next_s.din_sync = s.din_meta;
        next_s.frame_valid = 1'b0;
        if (sync_fall) begin
            next_s.state = RX_SHIFT;
            next_s.count = 5'h00;
        end else begin
            unique case (s.state)
                RX_IDLE: begin
                    next_s.state = RX_IDLE;
                end
                RX_SHIFT: begin
                    if (sync_rise) begin
                        next_s.state = RX_IDLE; // Short frame dropped
                    end else if (sclk_fall) begin
                        next_s.shift = {s.shift[22:0], s.din_sync};
                        next_s.count = s.count + 5'h01;
                        if (s.count == 5'(FRAME_BITS - 1)) begin
                            next_s.state = RX_FULL;
                        end
                    end
                end
                RX_FULL: begin
                    if (sync_rise) begin
                        next_s.state = RX_IDLE;
                        next_s.frame_valid = 1'b1;
                        next_s.frame = frame_type'(s.shift);
                    end
                end
                default: begin
                    next_s.state = RX_IDLE;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '{sclk_meta: 1'b1, sclk_sync: 1'b1, sclk_prev: 1'b1,
                   sync_meta: 1'b1, sync_sync: 1'b1, sync_prev: 1'b1,
                   state: RX_IDLE, default: '0};
        end else if (clk_en_in) begin
            s <= next_s;
        end
    end

    default clocking rx_cb @(posedge clk_sys_in iff clk_en_in);
    endclocking
    default disable iff (!rst_n_in);

    a_full_frame_only: assert property (
        frame_valid_out |-> $past(s.count) == 5'(FRAME_BITS))
        else $error("Frame delivered without 24 bits");
endmodule : dac_frame_receiver

// >>> verilog/dac_output_config.sv
// Output configuration register and channel monitor decoding
`timescale 1ns/1ps
module dac_output_config
    import dac_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    // Serial command port
    input wire logic sync_n_in,
    input wire logic sclk_in,
    input wire logic din_in,
    output logic sdo_out,
    // Load strobe and die temperature
    input wire logic load_strobe_n_in,
    input wire logic over_temp_in,
    // Amplifier and reference control
    output logic amps_powered_down_out,
    output logic amps_hiz_out,
    output logic amps_load_to_ground_out,
    output logic internal_ref_en_out,
    output logic ref_level_2v5_out,
    output logic current_boost_out,
    output logic thermal_shutdown_out,
    // Monitor routing
    output logic monitor_mode_out,
    output logic monitor_route_en_out,
    output logic [5:0] monitor_channel_out,
    output logic monitor_hiz_out,
    // Toggle selection per channel
    output logic [CHANNELS-1:0] toggle_select_b_out
);
    typedef struct packed {
        config_type cfg;
        logic [5:0] mon_sel;
        logic soft_pd;
        logic thermal_trip;
        logic temp_meta;
        logic temp_sync;
        logic load_strobe_meta;
        logic load_strobe_sync;
        logic load_strobe_prev;
        logic [CHANNELS-1:0] toggle_sel;
        logic [23:0] readback;
    } main_reg_type;

    main_reg_type s;
    main_reg_type next_s;
    frame_type frame;
    logic frame_valid;
    logic sclk_rise;
    logic load_strobe_fall;
    logic powered_down;
    logic cmd_write;

    // Special command match on both selects low and address
    function automatic logic is_cmd(input frame_type f, input logic [5:0] addr);
        is_cmd = !f.register_select_high && !f.register_select_low
            && (f.channel_address_field == addr);
    endfunction : is_cmd

    // Serial frame receiver
    dac_frame_receiver u_rx (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in),
        .sync_n_in(sync_n_in),
        .sclk_in(sclk_in),
        .din_in(din_in),
        .frame_out(frame),
        .frame_valid_out(frame_valid),
        .sclk_rise_out(sclk_rise)
    );

    // Derived strobes
    assign load_strobe_fall = s.load_strobe_prev & ~s.load_strobe_sync;
    assign powered_down = s.soft_pd | s.thermal_trip;
    assign cmd_write = frame_valid && !frame.rw && !s.soft_pd;

    // Next state of the register bank
    always_comb begin
        next_s = s;
        next_s.temp_meta = over_temp_in;
        next_s.temp_sync = s.temp_meta;
        next_s.load_strobe_meta = load_strobe_n_in;
        next_s.load_strobe_sync = s.load_strobe_meta;
        next_s.load_strobe_prev = s.load_strobe_sync;
        if (sclk_rise) begin
            next_s.readback = {s.readback[22:0], 1'b0};
        end
        if (frame_valid && frame.rw && is_cmd(frame, ADDR_CONFIG)) begin
            next_s.readback = {READBACK_PAD, s.cfg};
        end
        if (cmd_write) begin
            if (is_cmd(frame, ADDR_CONFIG)) begin
                next_s.cfg = config_type'(frame.command_data_field & CONFIG_WRITE_MASK);
            end
            if (is_cmd(frame, ADDR_MONITOR)) begin
                next_s.mon_sel = frame.command_data_field[13:8];
            end
            if (is_cmd(frame, ADDR_SOFT_PD)) begin
                next_s.soft_pd = 1'b1;
            end
            if (is_cmd(frame, ADDR_SOFT_RESET)) begin
                next_s.cfg = config_type'(CONFIG_RESET);
                next_s.mon_sel = MON_THREE_STATE;
            end
        end
        if (frame_valid && !frame.rw && is_cmd(frame, ADDR_SOFT_PU)) begin
            next_s.soft_pd = 1'b0;
            if (!s.temp_sync) begin
                next_s.thermal_trip = 1'b0;
            end
        end
        if (s.cfg.thermal_shutdown_enable_bit && s.temp_sync) begin
            next_s.thermal_trip = 1'b1;
        end
        // group g covers channels 8g to 8g+7
        for (int g = 0; g < TOGGLE_GROUPS; g++) begin
            if (!s.cfg.toggle_group_enables[g]) begin
                next_s.toggle_sel[g*GROUP_SIZE +: GROUP_SIZE] = '0;
            end else if (load_strobe_fall) begin
                next_s.toggle_sel[g*GROUP_SIZE +: GROUP_SIZE] =
                    ~s.toggle_sel[g*GROUP_SIZE +: GROUP_SIZE];
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '{cfg: config_type'(CONFIG_RESET), mon_sel: MON_THREE_STATE,
                   load_strobe_meta: 1'b1, load_strobe_sync: 1'b1, load_strobe_prev: 1'b1, default: '0};
        end else if (clk_en_in) begin
            s <= next_s;
        end
    end

    // Amplifier state while powered down
    // float or ground load
    assign amps_powered_down_out = powered_down;
    assign amps_hiz_out = powered_down & s.cfg.amp_powerdown_state_bit;
    assign amps_load_to_ground_out = powered_down & ~s.cfg.amp_powerdown_state_bit;
    assign thermal_shutdown_out = s.thermal_trip;

    // Reference and boost controls
    // internal reference enable
    assign internal_ref_en_out = s.cfg.reference_source_bit & ~s.soft_pd;
    assign ref_level_2v5_out = internal_ref_en_out & s.cfg.reference_level_bit;
    assign current_boost_out = s.cfg.current_boost_bit;

    // Monitor routing on the last channel pin
    // shared pin becomes monitor
    assign monitor_mode_out = s.cfg.monitor_enable_bit;
    assign monitor_route_en_out = s.cfg.monitor_enable_bit
        && (s.mon_sel <= MON_LAST_CHANNEL);
    assign monitor_channel_out = s.mon_sel;
    // code 63 floats, reserved codes float too
    assign monitor_hiz_out = s.cfg.monitor_enable_bit && (s.mon_sel > MON_LAST_CHANNEL);

    // Readback and toggle outputs
    assign sdo_out = s.readback[23];
    assign toggle_select_b_out = s.toggle_sel;

    default clocking main_cb @(posedge clk_sys_in iff clk_en_in);
    endclocking
    default disable iff (!rst_n_in);

    a_config_write_mask: assert property (
        cmd_write && is_cmd(frame, ADDR_CONFIG)
        |=> s.cfg == config_type'($past(frame.command_data_field) & CONFIG_WRITE_MASK))
        else $error("Config write not stored");
    a_unused_bits_zero: assert property (
        !s.cfg.unused_bit_7 && !s.cfg.unused_bit_1 && !s.cfg.unused_bit_0)
        else $error("Ignored config bit set");
    a_powerdown_pin_state: assert property (
        cmd_write && is_cmd(frame, ADDR_SOFT_PD)
        |=> amps_powered_down_out && (amps_hiz_out != amps_load_to_ground_out))
        else $error("Power-down state not applied");
    a_thermal_trip_set: assert property (
        s.cfg.thermal_shutdown_enable_bit && s.temp_sync |=> amps_powered_down_out)
        else $error("Thermal trip missed");
    a_thermal_needs_enable: assert property (
        $rose(thermal_shutdown_out) |-> $past(s.cfg.thermal_shutdown_enable_bit))
        else $error("Thermal trip while disabled");
    a_thermal_hold_hot: assert property (
        thermal_shutdown_out && s.temp_sync |=> thermal_shutdown_out)
        else $error("Thermal trip released while hot");
    a_monitor_route_set: assert property (
        cmd_write && is_cmd(frame, ADDR_MONITOR) && s.cfg.monitor_enable_bit
        && frame.command_data_field[13:8] <= MON_LAST_CHANNEL
        |=> monitor_route_en_out
        && monitor_channel_out == $past(frame.command_data_field[13:8]))
        else $error("Monitor channel not routed");
    a_monitor_three_state: assert property (
        monitor_mode_out && monitor_channel_out == MON_THREE_STATE
        |-> monitor_hiz_out && !monitor_route_en_out)
        else $error("Monitor code 63 not three-stated");
    a_monitor_off_normal: assert property (
        !monitor_mode_out |-> !monitor_route_en_out && !monitor_hiz_out)
        else $error("Monitor active while disabled");
    a_toggle_group_swap: assert property (
        load_strobe_fall && s.cfg.toggle_group_enables[4]
        |=> toggle_select_b_out[39:32] == ~$past(toggle_select_b_out[39:32]))
        else $error("Toggle group did not swap");
    a_toggle_group_off: assert property (
        !s.cfg.toggle_group_enables[0] |=> toggle_select_b_out[7:0] == 8'h00)
        else $error("Disabled toggle group left on B");

    c_config_write: cover property (cmd_write && is_cmd(frame, ADDR_CONFIG));
    c_monitor_route: cover property (monitor_route_en_out);
    c_thermal_trip: cover property ($rose(thermal_shutdown_out));
    c_toggle_swap: cover property (load_strobe_fall && s.cfg.toggle_group_enables != 5'h00);
endmodule : dac_output_config
